//--- fov_regs.svh
// Register map, field positions and constants of the FPU overflow/underflow flag block.
`ifndef FOV_REGS_SVH
`define FOV_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FOV_STATUS_OFS 8'h00
`define FOV_OPND_OFS 8'h04
`define FOV_OPCMD_OFS 8'h08
`define FOV_RESULT_OFS 8'h0c
`define FOV_FLAGWR_OFS 8'h10
`define FOV_G12EN_OFS 8'h14
`define FOV_PEND_OFS 8'h18
`define FOV_ISTAT_OFS 8'h1c
`define FOV_IMASK_OFS 8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FOV_LUF_BIT 0
`define FOV_LVF_BIT 1
`define FOV_FLAG_MASK 32'h0000_0003
`define FOV_G12_LUF_BIT 6
`define FOV_G12_LVF_BIT 7
`define FOV_G12_OFF_MASK 16'hff3f
`define FOV_G12_ON_MASK 16'h00c0
`define FOV_EV_UF 0
`define FOV_EV_OV 1
`define FOV_EV_EST 2
`define FOV_EV_W 3
`define FOV_STATUS_RST 32'h0000_0000
`define FOV_G12EN_RST 16'h0000
`define FOV_EXP_MAX 8'hff
`define FOV_EXP_ZERO 8'h00
`define FOV_RECIP_MAGIC 31'h7ef3_11c7
`define FOV_ISQRT_MAGIC 31'h5f37_59df

`endif

//--- fov_pkg.sv
// Types shared by the FPU overflow/underflow flag block.
package fov_pkg;

  typedef enum logic [1:0] {
    fov_op_none = 2'b00,
    fov_op_recip = 2'b01,
    fov_op_isqrt = 2'b10,
    fov_op_rsvd = 2'b11
  } fov_op_t;

  typedef struct packed {
    logic valid;
    logic uf;
    logic ov;
  } fov_arith_t;

endpackage

//--- fov_flags.sv
// FPU latched overflow/underflow flags, estimate unit and group-12 interrupt logic.
`timescale 1ns/1ps
`default_nettype none
`include "fov_regs.svh"

module fov_flags
  import fov_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // Core clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire fov_arith_t arith, // Flag report from the arithmetic datapath.
  input wire logic [1:0] g12_ack, // Group-12 acknowledge, bit 0 underflow, bit 1 overflow.
  output logic [1:0] flag_line, // Latched flag lines toward group 12.
  output logic [1:0] g12_int, // Enabled pending group-12 requests.
  output logic irq // Block status interrupt, level.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] status;
  logic [31:0] operand;
  logic [31:0] result;
  logic [15:0] g12_en;
  logic [1:0] pend;
  logic [`FOV_EV_W-1:0] istat;
  logic [`FOV_EV_W-1:0] imask;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state keeps prdata and pready straight from flip-flops.
  // A write lands only at the edge where pready is high, so a stretched setup phase writes nothing;
  // an access phase held past pready writes the register again two cycles later.
  wire logic acc = psel & penable;
  wire logic acc_first = acc & ~pready;
  wire logic wr = acc & pready & pwrite;
  wire logic sel_status = hit(paddr, `FOV_STATUS_OFS);
  wire logic sel_opnd = hit(paddr, `FOV_OPND_OFS);
  wire logic sel_opcmd = hit(paddr, `FOV_OPCMD_OFS);
  wire logic sel_result = hit(paddr, `FOV_RESULT_OFS);
  wire logic sel_flagwr = hit(paddr, `FOV_FLAGWR_OFS);
  wire logic sel_g12en = hit(paddr, `FOV_G12EN_OFS);
  wire logic sel_pend = hit(paddr, `FOV_PEND_OFS);
  wire logic sel_istat = hit(paddr, `FOV_ISTAT_OFS);
  wire logic sel_imask = hit(paddr, `FOV_IMASK_OFS);
  wire logic mapped = sel_status | sel_opnd | sel_opcmd | sel_result | sel_flagwr |
                      sel_g12en | sel_pend | sel_istat | sel_imask;
  wire logic wr_status = wr & sel_status;
  wire logic wr_opnd = wr & sel_opnd;
  wire logic wr_opcmd = wr & sel_opcmd;
  wire logic wr_flagwr = wr & sel_flagwr;
  wire logic wr_g12en = wr & sel_g12en;
  wire logic wr_istat = wr & sel_istat;
  wire logic wr_imask = wr & sel_imask;

  wire logic [31:0] rd_data =
    sel_status ? status :
    sel_opnd ? operand :
    sel_opcmd ? 32'h0000_0000 :
    sel_result ? result :
    sel_flagwr ? 32'h0000_0000 :
    sel_g12en ? {16'h0000, g12_en} :
    sel_pend ? {30'h0000_0000, pend} :
    sel_istat ? {29'h0000_0000, istat} :
    sel_imask ? {29'h0000_0000, imask} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // Estimate unit
  // ----------------------------------------------------------------
  // Bit-trick seeds: cheap, and the value software gets for refinement.
  wire fov_op_t op = fov_op_t'(pwdata[1:0]);
  wire logic is_recip = (op == fov_op_recip);
  wire logic is_isqrt = (op == fov_op_isqrt);
  // Codes other than the two estimates are no-ops: result and flags stay put.
  wire logic est_go = wr_opcmd & (is_recip | is_isqrt);
  // Operand and result load through next_ values, so every flip-flop takes a
  // new value on each edge and no load enable is inferred.
  wire logic [31:0] next_operand = wr_opnd ? pwdata : operand;
  wire logic [30:0] mag = operand[30:0];
  wire logic [30:0] recip_mag = `FOV_RECIP_MAGIC - mag;
  wire logic [30:0] isqrt_mag = `FOV_ISQRT_MAGIC - {1'b0, mag[30:1]};
  wire logic [31:0] recip_val = {operand[31], recip_mag};
  wire logic [31:0] isqrt_val = {1'b0, isqrt_mag};
  wire logic [31:0] est_val = is_recip ? recip_val : isqrt_val;
  wire logic [31:0] next_result = est_go ? est_val : result;
  wire logic [7:0] opnd_exp = operand[30:23];
  // Flags raised here track operand classes, not the result.
  wire logic est_uf = est_go & (opnd_exp == `FOV_EXP_MAX);
  wire logic est_ov = est_go & (opnd_exp == `FOV_EXP_ZERO);

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // A hardware set wins over a simultaneous clear or overwrite.
  // Flag write only clears; software that wants a flag set writes the status word.
  wire logic set_uf = (arith.valid & arith.uf) | est_uf;
  wire logic set_ov = (arith.valid & arith.ov) | est_ov;
  wire logic [1:0] set_f = {set_ov, set_uf};
  wire logic [31:0] base = wr_status ? pwdata : status;
  wire logic [1:0] clr_f = wr_flagwr ? pwdata[1:0] : 2'b00;
  wire logic [1:0] next_flags = set_f | (base[1:0] & ~clr_f);
  wire logic [31:0] next_status = {base[31:2], next_flags};
  wire logic [1:0] rise = next_flags & ~status[1:0];

  // ----------------------------------------------------------------
  // Group-12 pending and enable
  // ----------------------------------------------------------------
  // Pending follows the rising edge of a flag, so a flag left set raises one request,
  // not one per cycle; the enable gates the request, never the pending bit.
  wire logic [15:0] next_g12_en = wr_g12en ? pwdata[15:0] : g12_en;
  wire logic [1:0] next_en_bits = {next_g12_en[`FOV_G12_LVF_BIT],
                                   next_g12_en[`FOV_G12_LUF_BIT]};
  logic [1:0] next_pend;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      // Only a taken request clears pending; no bus path writes it.
      assign next_pend[gi] = rise[gi] |
                             (pend[gi] & ~(g12_ack[gi] & g12_int[gi]));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pend[gi] <= 1'b0;
          g12_int[gi] <= 1'b0;
        end else begin
          pend[gi] <= next_pend[gi];
          g12_int[gi] <= next_pend[gi] & next_en_bits[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Block interrupt
  // ----------------------------------------------------------------
  // Events are edges as well: a level source would fire again after every clear.
  wire logic [`FOV_EV_W-1:0] events = {est_go, rise[1], rise[0]};
  wire logic [`FOV_EV_W-1:0] w1c = wr_istat ? pwdata[`FOV_EV_W-1:0] : '0;
  wire logic [`FOV_EV_W-1:0] next_istat = events | (istat & ~w1c);
  wire logic [`FOV_EV_W-1:0] next_imask = wr_imask ? pwdata[`FOV_EV_W-1:0] : imask;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= `FOV_STATUS_RST;
      flag_line <= 2'b00;
    end else begin
      status <= next_status;
      flag_line <= next_flags;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand <= 32'h0000_0000;
      result <= 32'h0000_0000;
    end else begin
      operand <= next_operand;
      result <= next_result;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g12_en <= `FOV_G12EN_RST;
      istat <= '0;
      imask <= '0;
      irq <= 1'b0;
    end else begin
      g12_en <= next_g12_en;
      istat <= next_istat;
      imask <= next_imask;
      irq <= |(next_istat & next_imask);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_first;
      prdata <= (acc_first & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= acc_first & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  recip_result_a: assert property (
    (wr_opcmd && pwdata[1:0] == 2'b01) |=>
      result == {$past(operand[31]), 31'(`FOV_RECIP_MAGIC - $past(operand[30:0]))})
    else $error("reciprocal estimate result wrong");

  est_flag_a: assert property (
    (est_go && opnd_exp == `FOV_EXP_ZERO) |=> status[`FOV_LVF_BIT])
    else $error("estimate flag behaviour changed");

  status_restore_a: assert property (
    (wr_status && !set_uf && !set_ov) |=> status == $past(pwdata))
    else $error("status word not restored");

  flag_pos_a: assert property (
    flag_line == 2'(status & `FOV_FLAG_MASK))
    else $error("flag lines differ from status bits");

  flag_clear_a: assert property (
    (wr_flagwr && pwdata[1:0] == 2'b11 && !set_uf && !set_ov) |=>
      (status[1:0] == 2'b00 && status[31:2] == $past(status[31:2])))
    else $error("flag clear failed or disturbed status");

  line_pend_a: assert property (
    $rose(flag_line[1]) |-> pend[1] ##1 (pend[1] || $past(g12_ack[1] && g12_int[1])))
    else $error("overflow line not latched pending");

  g12_gate_a: assert property (
    g12_int == (pend & {g12_en[`FOV_G12_LVF_BIT], g12_en[`FOV_G12_LUF_BIT]}))
    else $error("group-12 request not gated by enable");

  pend_hold_a: assert property (
    (pend[0] && !g12_en[`FOV_G12_LUF_BIT] && !wr_g12en) [*2] |-> pend[0] && !g12_int[0])
    else $error("disabled pending underflow lost");

  sticky_a: assert property (
    (status[0] && !wr_status && !wr_flagwr) |=> status[0])
    else $error("underflow flag not sticky");

  irq_level_a: assert property (
    irq == |(istat & imask))
    else $error("interrupt output mismatch");

  isqrt_result_a: assert property (
    (est_go && is_isqrt) |=>
      result == {1'b0, 31'(`FOV_ISQRT_MAGIC - {1'b0, $past(operand[30:1])})})
    else $error("inverse square root estimate result wrong");

  result_hold_a: assert property (
    !est_go |=> $stable(result))
    else $error("result changed without an estimate");

  est_uf_flag_a: assert property (
    (est_go && opnd_exp == `FOV_EXP_MAX) |=> status[`FOV_LUF_BIT])
    else $error("estimate underflow flag behaviour changed");

  flag_only_a: assert property (
    !wr_status |=> status[31:2] == $past(status[31:2]))
    else $error("upper status bits moved without a status write");

  flag_clear_uf_a: assert property (
    (wr_flagwr && pwdata[`FOV_LUF_BIT] && !set_uf) |=> !status[`FOV_LUF_BIT])
    else $error("underflow flag not cleared");

  line_pend_uf_a: assert property (
    $rose(flag_line[0]) |-> pend[0])
    else $error("underflow line not latched pending");

  pend_keep_uf_a: assert property (
    (pend[0] && !(g12_ack[0] && g12_int[0])) |=> pend[0])
    else $error("underflow pending lost without acknowledge");

  pend_keep_ov_a: assert property (
    (pend[1] && !(g12_ack[1] && g12_int[1])) |=> pend[1])
    else $error("overflow pending lost without acknowledge");

  late_take_a: assert property (
    (pend[0] && !g12_int[0] && wr_g12en && pwdata[`FOV_G12_LUF_BIT]) |=> g12_int[0])
    else $error("pending underflow not taken on enable");

  gate_off_a: assert property (
    (wr_g12en && !pwdata[`FOV_G12_LVF_BIT]) |=> !g12_int[1])
    else $error("overflow request not gated off");

  enable_load_a: assert property (
    wr_g12en |=> g12_en == $past(pwdata[15:0]))
    else $error("group-12 enable write lost");

  sticky_ov_a: assert property (
    (status[1] && !wr_status && !wr_flagwr) |=> status[1])
    else $error("overflow flag not sticky");

  set_wins_a: assert property (
    (arith.valid && arith.uf) |=> status[`FOV_LUF_BIT])
    else $error("underflow set lost to a clear");

  opnd_load_a: assert property (
    wr_opnd |=> operand == $past(pwdata))
    else $error("operand write lost");

  status_read_a: assert property (
    (acc_first && !pwrite && sel_status) |=> prdata == $past(status))
    else $error("status word read back wrong");

  est_event_a: assert property (
    est_go |=> istat[`FOV_EV_EST])
    else $error("estimate event not recorded");

  istat_clear_a: assert property (
    (wr_istat && pwdata[`FOV_EV_UF] && !rise[0]) |=> !istat[`FOV_EV_UF])
    else $error("underflow event not cleared");

  imask_load_a: assert property (
    wr_imask |=> imask == $past(pwdata[`FOV_EV_W-1:0]))
    else $error("interrupt mask write lost");

  // Bus-side checks carry no tag: they guard the handshake, not a flag rule.
  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  rdata_idle_a: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data shown outside a response");

  err_pair_a: assert property (
    pslverr |-> pready)
    else $error("error response without ready");

  cov_recip_c: cover property (est_go && is_recip ##1 status[1]);
  cov_isqrt_c: cover property (est_go && is_isqrt);
  cov_late_c: cover property (pend[0] && !g12_int[0] ##[1:20] g12_int[0]);
  cov_clear_c: cover property (wr_flagwr && status[1:0] == 2'b11);
  cov_est_flag_c: cover property (est_go && opnd_exp == `FOV_EXP_ZERO);

endmodule
`default_nettype wire

//--- fov_partner.sv
// Model of the group-12 interrupt controller that acknowledges block requests.
`timescale 1ns/1ps
`default_nettype none

module fov_partner (
  input wire logic clk, // Core clock.
  input wire logic nrst, // Reset, active low.
  input wire logic take, // High while requests may be taken.
  input wire logic [1:0] g12_int, // Requests from the block.
  output logic [1:0] g12_ack // Acknowledge toward the block.
);
  // Pending bits are released only by acknowledge, never by a direct write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g12_ack <= 2'h0;
    end else begin
      g12_ack <= take ? (g12_int & ~g12_ack) : 2'h0;
    end
  end
endmodule

`default_nettype wire

//--- fpu_overflow_underflow_flags_test.sv
// Self-checking bench of the FPU latched flag block.
`timescale 1ns/1ps
`default_nettype none
`include "fov_regs.svh"

module fpu_overflow_underflow_flags_test;
  import fov_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, take = 1, seen = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq;
  fov_arith_t arith = '0;
  logic [1:0] g12_ack, flag_line, g12_int;
  int errors = 0, checked = 0;

  fov_flags u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arith(arith), .g12_ack(g12_ack), .flag_line(flag_line), .g12_int(g12_int), .irq(irq));
  fov_partner u_ctl (.clk(clk), .nrst(nrst), .take(take), .g12_int(g12_int), .g12_ack(g12_ack));

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (g12_int === 2'h3) seen <= 1'b1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until pready is sampled high, so wait states cost nothing.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic pulse(input logic u, input logic o);
    @(posedge clk) arith <= '{valid: 1'b1, uf: u, ov: o};
    @(posedge clk) arith <= '0;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] q;
    apb(0, `FOV_STATUS_OFS, 0, q); chk(q, `FOV_STATUS_RST);
    apb(0, `FOV_G12EN_OFS, 0, q); chk(q, 32'h0);
    apb(1, 8'h40, 32'h1, q); chk({31'h0, err}, 32'h1);
  endtask

  task automatic s_estimate();
    logic [31:0] q, op, saved, exp, sv, fl;
    for (int i = 0; i < 4; i++) begin
      // Operands are fixed by hand: none is zero, the isqrt ones are positive.
      op = (i == 0) ? 32'hbf80_0000 : (i == 1) ? 32'h4080_0000 :
           (i == 2) ? 32'h7f80_0000 : 32'h0000_0100;
      exp = (i % 2) ? {1'b0, `FOV_ISQRT_MAGIC - (op[30:0] >> 1)} :
                      {op[31], `FOV_RECIP_MAGIC - op[30:0]};
      sv = (i < 2) ? 32'habcd_0001 + i : 32'habcd_0000;
      fl = (i == 2) ? 32'h1 : (i == 3) ? 32'h2 : 32'h0;
      apb(1, `FOV_STATUS_OFS, sv, q);
      apb(0, `FOV_STATUS_OFS, 0, saved); chk(saved, sv);
      apb(1, `FOV_OPND_OFS, op, q);
      apb(1, `FOV_OPCMD_OFS, (i % 2) + 1, q);
      apb(0, `FOV_RESULT_OFS, 0, q); chk(q, exp);
      apb(0, `FOV_STATUS_OFS, 0, q); chk(q, sv | fl);
      apb(1, `FOV_STATUS_OFS, saved, q);
      apb(0, `FOV_STATUS_OFS, 0, q); chk(q, sv);
    end
    apb(1, `FOV_OPCMD_OFS, 32'h3, q);
    apb(0, `FOV_RESULT_OFS, 0, q); chk(q, exp);
    apb(0, `FOV_ISTAT_OFS, 0, q); chk(q & 32'h4, 32'h4);
  endtask

  task automatic s_clear();
    logic [31:0] q;
    apb(1, `FOV_STATUS_OFS, 32'h0000_00f0, q);
    pulse(1, 1);
    repeat (8) @(posedge clk);
    chk(flag_line, 2'h3);
    apb(0, `FOV_STATUS_OFS, 0, q); chk(q & `FOV_FLAG_MASK, 32'h3);
    apb(1, `FOV_FLAGWR_OFS, 32'h3, q);
    apb(0, `FOV_STATUS_OFS, 0, q); chk(q, 32'h0000_00f0);
  endtask

  task automatic s_gate();
    logic [31:0] q;
    apb(0, `FOV_PEND_OFS, 0, q); chk(q, 32'h3);
    chk(g12_int, 2'h0);
    apb(1, `FOV_G12EN_OFS, `FOV_G12_ON_MASK | 16'h0001, q);
    apb(0, `FOV_PEND_OFS, 0, q); chk(q, 32'h0);
    chk(seen, 1'b1);
    apb(0, `FOV_G12EN_OFS, 0, q); chk(q, 32'h0000_00c1);
    apb(1, `FOV_G12EN_OFS, q & 32'(`FOV_G12_OFF_MASK), q);
    apb(0, `FOV_G12EN_OFS, 0, q); chk(q, 32'h0000_0001);
    pulse(1, 0);
    chk(g12_int, 2'h0);
    apb(0, `FOV_PEND_OFS, 0, q); chk(q, 32'h1);
    apb(1, `FOV_G12EN_OFS, q | 32'(`FOV_G12_ON_MASK), q);
    apb(0, `FOV_PEND_OFS, 0, q); chk(q, 32'h0);
  endtask

  task automatic s_irq();
    logic [31:0] q;
    for (int m = 1; m >= 0; m--) begin
      apb(1, `FOV_FLAGWR_OFS, 32'h3, q);
      apb(1, `FOV_ISTAT_OFS, 32'h7, q);
      apb(1, `FOV_IMASK_OFS, m, q);
      pulse(1, 0);
      chk(irq, m[0]);
    end
    apb(1, `FOV_IMASK_OFS, 32'h1, q);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1, `FOV_ISTAT_OFS, 32'h1, q);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    s_reset();
    s_estimate();
    s_clear();
    s_gate();
    s_irq();
    wrap_up();
  end
endmodule

`default_nettype wire
